//--- rtl/wake_event_status_logic.sv
// Contract
// - magic packet sets status bit 5
// - broadcast frame sets status bit 4
// - resume clears both status bits when enabled
// - bit 3 enables station address wake
// - bit 2 enables pattern frame wake
// - bit 1 enables magic packet wake
// - bit 0 enables broadcast wake; reset zero
// - resume clears all four enables when enabled
// - wake source register at 144h
// - no capture while entering suspend
// - no capture once wakeup started
// - all matching source bits set together
// - source bits held until software clears; LPI bits also clear while EEE is off
// - bits 31:20 flag waking pins
// - bits 16/15 flag IPv6/IPv4 SYN
// - bit 14 LPI tx exit, gated
// - bit 13 LPI rx exit, gated
// - bit 12 filter engine frame
// - bit 11 station address frame
// - bits 10/9 magic and broadcast frame
// - bit 8 pattern frame
// - bits 4:0 matching filter index
// - filter bank has 32 filters
//
// The implementer's own choice: the APB slave port.
module wake_event_status_logic #(
  parameter int FILTERS = wake_pkg::FILTER_COUNT
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire wake_pkg::wake_events_t events,
  input wire logic energy_efficient_enable,
  input wire logic suspending,
  input wire logic waking,
  input wire logic resumeDone,
  output logic wakeRequest,
  output logic station_addr_wake_en,
  output logic pattern_frame_wake_en,
  output logic magic_wake_en,
  output logic bcast_wake_en
);

  // ==========================================
  // bus decode
  logic access;
  logic wrCtrl;
  logic wrSrc;
  logic wrCfg;
  logic mapped;
  logic [31:0] wmask;
  logic captureOpen;

  assign access = psel && penable;
  assign mapped = (paddr == wake_pkg::WAKE_CTRL_OFS) || (paddr == wake_pkg::WAKE_SRC_OFS) ||
                  (paddr == wake_pkg::WAKE_CFG_OFS);
  assign wrCtrl = access && pwrite && (paddr == wake_pkg::WAKE_CTRL_OFS);
  assign wrSrc = access && pwrite && (paddr == wake_pkg::WAKE_SRC_OFS);
  assign wrCfg = access && pwrite && (paddr == wake_pkg::WAKE_CFG_OFS);
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{pstrb[i]}};
    end
  end

  wake_capture_gate gate (
    .clk_sys(clk_sys),
    .rst(rst),
    .suspending(suspending),
    .waking(waking),
    .resumeDone(resumeDone),
    .captureOpen(captureOpen)
  );

  // ==========================================
  // config register
  logic resClrStatus_r;
  logic resClrEnables_r;
  logic lpiTxEn_r;
  logic lpiRxEn_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      resClrStatus_r <= 1'b0;
      resClrEnables_r <= 1'b0;
      lpiTxEn_r <= 1'b0;
      lpiRxEn_r <= 1'b0;
    end else if (wrCfg && pstrb[0]) begin
      resClrStatus_r <= pwdata[wake_pkg::RES_CLR_STATUS_BIT];
      resClrEnables_r <= pwdata[wake_pkg::RES_CLR_ENABLES_BIT];
      lpiTxEn_r <= pwdata[wake_pkg::LPI_TX_EN_BIT];
      lpiRxEn_r <= pwdata[wake_pkg::LPI_RX_EN_BIT];
    end
  end

  // ==========================================
  // wake enables
  logic [3:0] enables_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      enables_r <= 4'h0;
    end else if (resumeDone && resClrEnables_r) begin
      enables_r <= 4'h0;
    end else if (wrCtrl && pstrb[0]) begin
      enables_r <= pwdata[3:0];
    end
  end

  assign bcast_wake_en = enables_r[wake_pkg::BCAST_WAKE_EN_BIT];
  assign magic_wake_en = enables_r[wake_pkg::MAGIC_WAKE_EN_BIT];
  assign pattern_frame_wake_en = enables_r[wake_pkg::PATTERN_WAKE_EN_BIT];
  assign station_addr_wake_en = enables_r[wake_pkg::STATION_WAKE_EN_BIT];

  // ==========================================
  // magic and broadcast seen flags
  logic magic_seen_r;
  logic bcast_seen_r;
  logic magicSet;
  logic bcastSet;

  assign magicSet = events.magic && magic_wake_en;
  assign bcastSet = events.bcast && bcast_wake_en;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      magic_seen_r <= 1'b0;
    end else if (magicSet) begin
      magic_seen_r <= 1'b1;
    end else if (resumeDone && resClrStatus_r) begin
      magic_seen_r <= 1'b0;
    end else if (wrCtrl && pstrb[0] && pwdata[wake_pkg::MAGIC_SEEN_BIT]) begin
      magic_seen_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bcast_seen_r <= 1'b0;
    end else if (bcastSet) begin
      bcast_seen_r <= 1'b1;
    end else if (resumeDone && resClrStatus_r) begin
      bcast_seen_r <= 1'b0;
    end else if (wrCtrl && pstrb[0] && pwdata[wake_pkg::BCAST_SEEN_BIT]) begin
      bcast_seen_r <= 1'b0;
    end
  end

  // ==========================================
  // wake source capture
  logic [31:0] srcEvents;
  logic [31:0] src_r;
  logic [31:0] src_nxt;
  logic [wake_pkg::FILTER_INDEX_W-1:0] index_r;
  logic [wake_pkg::FILTER_INDEX_W-1:0] index_nxt;
  logic patternHit;
  logic idxValid;

  assign idxValid = 32'(events.patternIndex) < FILTERS;
  assign patternHit = events.pattern && pattern_frame_wake_en && idxValid;

  always_comb begin
    srcEvents = wake_pkg::RESET_WORD;
    srcEvents[wake_pkg::PIN_FLAGS_LSB +: wake_pkg::PIN_COUNT] = events.pinWake;
    srcEvents[wake_pkg::V6_SYN_BIT] = events.v6Syn;
    srcEvents[wake_pkg::V4_SYN_BIT] = events.v4Syn;
    srcEvents[wake_pkg::LPI_TX_BIT] = events.lpiTxExit && lpiTxEn_r;
    srcEvents[wake_pkg::LPI_RX_BIT] = events.lpiRxExit && lpiRxEn_r;
    srcEvents[wake_pkg::FILTER_ENGINE_BIT] = events.filterEngine;
    srcEvents[wake_pkg::STATION_FRAME_BIT] = events.stationAddr && station_addr_wake_en;
    srcEvents[wake_pkg::MAGIC_FRAME_BIT] = magicSet;
    srcEvents[wake_pkg::BCAST_FRAME_BIT] = bcastSet;
    srcEvents[wake_pkg::PATTERN_FRAME_BIT] = patternHit;
    if (!captureOpen) begin
      srcEvents = wake_pkg::RESET_WORD;
    end
  end

  always_comb begin
    src_nxt = src_r;
    index_nxt = index_r;
    if (wrSrc) begin
      src_nxt = src_r & ~(pwdata & wmask & wake_pkg::SRC_WRITABLE);
      if (pstrb[0] && |pwdata[wake_pkg::FILTER_INDEX_W-1:0]) begin
        index_nxt = '0;
      end
    end
    src_nxt = src_nxt | srcEvents;
    if (patternHit && captureOpen) begin
      index_nxt = events.patternIndex;
    end
    if (!energy_efficient_enable) begin
      src_nxt[wake_pkg::LPI_TX_BIT] = 1'b0;
      src_nxt[wake_pkg::LPI_RX_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      src_r <= wake_pkg::RESET_WORD;
      index_r <= '0;
    end else begin
      src_r <= src_nxt;
      index_r <= index_nxt;
    end
  end

  assign wakeRequest = |srcEvents;

  // ==========================================
  // read data
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata <= wake_pkg::RESET_WORD;
    end else if (psel && !penable && !pwrite) begin
      prdata <= wake_pkg::RESET_WORD;
      unique case (paddr)
        wake_pkg::WAKE_CTRL_OFS: begin
          prdata[3:0] <= enables_r;
          prdata[wake_pkg::BCAST_SEEN_BIT] <= bcast_seen_r;
          prdata[wake_pkg::MAGIC_SEEN_BIT] <= magic_seen_r;
        end
        wake_pkg::WAKE_SRC_OFS: begin
          prdata <= src_r | {27'h0, index_r};
        end
        wake_pkg::WAKE_CFG_OFS: begin
          prdata[3:0] <= {lpiRxEn_r, lpiTxEn_r, resClrEnables_r, resClrStatus_r};
        end
        default: begin
          prdata <= wake_pkg::RESET_WORD;
        end
      endcase
    end
  end

  // ==========================================
  // checks
  magic_sets_a: assert property (@(posedge clk_sys) disable iff (rst)
    magicSet |=> magic_seen_r) else $error("magic flag not set");
  bcast_sets_a: assert property (@(posedge clk_sys) disable iff (rst)
    bcastSet |=> bcast_seen_r) else $error("broadcast flag not set");
  resume_status_a: assert property (@(posedge clk_sys) disable iff (rst)
    resumeDone && resClrStatus_r && !magicSet && !bcastSet |=> !magic_seen_r && !bcast_seen_r)
    else $error("resume left status");
  resume_enables_a: assert property (@(posedge clk_sys) disable iff (rst)
    resumeDone && resClrEnables_r |=> enables_r == 4'h0)
    else $error("resume left enables");
  enable_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    wrCtrl && pstrb[0] && !(resumeDone && resClrEnables_r) |=> enables_r == $past(pwdata[3:0]))
    else $error("enable write lost");
  no_capture_a: assert property (@(posedge clk_sys) disable iff (rst)
    (suspending || waking) && !wrSrc && energy_efficient_enable |=> src_r == $past(src_r))
    else $error("captured while closed");
  src_sticky_a: assert property (@(posedge clk_sys) disable iff (rst)
    !wrSrc && energy_efficient_enable |=> (src_r & $past(src_r)) == $past(src_r))
    else $error("source bit dropped");
  eee_low_a: assert property (@(posedge clk_sys) disable iff (rst)
    !energy_efficient_enable |=> !src_r[wake_pkg::LPI_TX_BIT] && !src_r[wake_pkg::LPI_RX_BIT])
    else $error("lpi bit while eee off");
  pattern_index_a: assert property (@(posedge clk_sys) disable iff (rst)
    patternHit && captureOpen |=> index_r == $past(events.patternIndex) &&
    src_r[wake_pkg::PATTERN_FRAME_BIT]) else $error("filter index wrong");
  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    src_r[19:17] == 3'h0 && src_r[7:0] == 8'h0) else $error("reserved bit set");

  magic_cov_c: cover property (@(posedge clk_sys) disable iff (rst) magicSet ##1 magic_seen_r);
  multi_cov_c: cover property (@(posedge clk_sys) disable iff (rst)
    srcEvents[wake_pkg::MAGIC_FRAME_BIT] && srcEvents[wake_pkg::BCAST_FRAME_BIT]);
  resume_cov_c: cover property (@(posedge clk_sys) disable iff (rst)
    resumeDone && resClrEnables_r && enables_r != 4'h0);
  clear_cov_c: cover property (@(posedge clk_sys) disable iff (rst) wrSrc && src_r != 32'h0);

endmodule

//--- rtl/wake_pkg.sv
package wake_pkg;

  // ==========================================
  // register map
  localparam logic [11:0] WAKE_CTRL_OFS = 12'h140;
  localparam logic [11:0] WAKE_SRC_OFS = 12'h144;
  localparam logic [11:0] WAKE_CFG_OFS = 12'h148;

  // ==========================================
  // wake control/status low bits
  localparam int BCAST_WAKE_EN_BIT = 0;
  localparam int MAGIC_WAKE_EN_BIT = 1;
  localparam int PATTERN_WAKE_EN_BIT = 2;
  localparam int STATION_WAKE_EN_BIT = 3;
  localparam int BCAST_SEEN_BIT = 4;
  localparam int MAGIC_SEEN_BIT = 5;

  // ==========================================
  // wake source fields
  localparam int PIN_FLAGS_LSB = 20;
  localparam int PIN_COUNT = 12;
  localparam int V6_SYN_BIT = 16;
  localparam int V4_SYN_BIT = 15;
  localparam int LPI_TX_BIT = 14;
  localparam int LPI_RX_BIT = 13;
  localparam int FILTER_ENGINE_BIT = 12;
  localparam int STATION_FRAME_BIT = 11;
  localparam int MAGIC_FRAME_BIT = 10;
  localparam int BCAST_FRAME_BIT = 9;
  localparam int PATTERN_FRAME_BIT = 8;
  localparam int FILTER_INDEX_W = 5;
  localparam int FILTER_COUNT = 32;
  localparam int FILTER_PATTERN_BYTES = 128;

  // ==========================================
  // config register bits
  localparam int RES_CLR_STATUS_BIT = 0;
  localparam int RES_CLR_ENABLES_BIT = 1;
  localparam int LPI_TX_EN_BIT = 2;
  localparam int LPI_RX_EN_BIT = 3;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [31:0] SRC_WRITABLE = 32'hFFF1_FF1F;

  // ==========================================
  // event strobes from the detectors
  typedef struct packed {
    logic [PIN_COUNT-1:0] pinWake;
    logic v6Syn;
    logic v4Syn;
    logic lpiTxExit;
    logic lpiRxExit;
    logic filterEngine;
    logic stationAddr;
    logic magic;
    logic bcast;
    logic pattern;
    logic [FILTER_INDEX_W-1:0] patternIndex;
  } wake_events_t;

endpackage

//--- rtl/wake_capture_gate.sv
module wake_capture_gate (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic suspending,
  input wire logic waking,
  input wire logic resumeDone,
  output logic captureOpen
);

  // ==========================================
  // capture window: closed while entering suspend or after wake start
  logic wakeLatched_r;

  always_ff @(posedge clk_sys) begin
    if (rst || resumeDone) begin
      wakeLatched_r <= 1'b0;
    end else if (waking) begin
      wakeLatched_r <= 1'b1;
    end
  end

  assign captureOpen = !suspending && !waking && !wakeLatched_r;

endmodule

//--- testbench/event_source_model.sv
module event_source_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic fire,
  input wire wake_pkg::wake_events_t want,
  output wake_pkg::wake_events_t events
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // detectors: one-cycle strobe per frame, all matches together
  always_ff @(posedge clk_sys) begin
    if (rst || !fire) begin
      events <= '0;
    end else begin
      events <= want;
    end
  end
endmodule

//--- testbench/tb_top.sv
`define CHK(a, e) begin testsRun++; if ((a) !== (e)) begin \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); failCount++; end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic eeeOn = 0, suspending = 0, waking = 0, resumeDone = 0, wakeRequest, fire = 0, err;
  logic [3:0] en;
  logic wakeSeen = 0;
  wake_pkg::wake_events_t events, want = '0;
  int failCount = 0, testsRun = 0;
  typedef struct {logic [25:0] ev; logic [31:0] src; logic [31:0] ctl;} row_t;
  row_t rows [11] = '{'{26'h2004000, 32'h8010_0000, 32'hF}, '{26'h2000, 32'h1_0000, 32'hF},
    '{26'h1000, 32'h8000, 32'hF}, '{26'h800, 32'h4000, 32'hF}, '{26'h400, 32'h2000, 32'hF},
    '{26'h200, 32'h1000, 32'hF}, '{26'h100, 32'h800, 32'hF}, '{26'h80, 32'h400, 32'h2F},
    '{26'h40, 32'h200, 32'h1F}, '{26'h3F, 32'h11F, 32'hF}, '{26'h1C0, 32'hE00, 32'h3F}};
  always #2 clk_sys = ~clk_sys;
  wake_event_status_logic DUT (.clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .events(events), .energy_efficient_enable(eeeOn),
    .suspending(suspending), .waking(waking), .resumeDone(resumeDone),
    .wakeRequest(wakeRequest), .station_addr_wake_en(en[3]), .pattern_frame_wake_en(en[2]),
    .magic_wake_en(en[1]), .bcast_wake_en(en[0]));
  event_source_model partner (.clk_sys(clk_sys), .rst(rst), .fire(fire), .want(want),
    .events(events));
  // ==========================================
  // bus and stimulus tasks
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n = 0;
    @(posedge clk_sys);
    psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do begin @(posedge clk_sys); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failCount++;
    rdat = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    `CHK(rdat, e)
  endtask
  task automatic hit(input logic [25:0] ev);
    @(posedge clk_sys);
    fire <= 1; want <= wake_pkg::wake_events_t'(ev);
    @(posedge clk_sys);
    fire <= 0;
    @(negedge clk_sys);
    wakeSeen = wakeRequest;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic pulse(input logic resume);
    @(posedge clk_sys);
    if (resume) resumeDone <= 1;
    else waking <= 1;
    @(posedge clk_sys);
    resumeDone <= 0;
    waking <= 0;
  endtask
  task automatic finishTest();
    if (failCount == 0 && testsRun > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 0;
    rdChk(wake_pkg::WAKE_CTRL_OFS, 32'h0);
    rdChk(wake_pkg::WAKE_SRC_OFS, 32'h0);
    rdChk(wake_pkg::WAKE_CFG_OFS, 32'h0);
    rdChk(12'hFFC, 32'h0);
    `CHK(err, 1'b1)
    xfer(wake_pkg::WAKE_CTRL_OFS, 1'b1, 32'hF);
    xfer(wake_pkg::WAKE_CFG_OFS, 1'b1, 32'hC);
    eeeOn <= 1;
    `CHK(en, 4'hF)
    foreach (rows[i]) begin
      hit(rows[i].ev);
      `CHK(wakeSeen, 1'b1)
      rdChk(wake_pkg::WAKE_SRC_OFS, rows[i].src);
      rdChk(wake_pkg::WAKE_CTRL_OFS, rows[i].ctl);
      xfer(wake_pkg::WAKE_SRC_OFS, 1'b1, 32'hFFFF_FFFF);
      xfer(wake_pkg::WAKE_CTRL_OFS, 1'b1, 32'h3F);
      rdChk(wake_pkg::WAKE_SRC_OFS, 32'h0);
    end
    eeeOn <= 0;
    hit(26'hC00);
    rdChk(wake_pkg::WAKE_SRC_OFS, 32'h0);
    eeeOn <= 1;
    xfer(wake_pkg::WAKE_CFG_OFS, 1'b1, 32'h0);
    hit(26'hC00);
    rdChk(wake_pkg::WAKE_SRC_OFS, 32'h0);
    xfer(wake_pkg::WAKE_CTRL_OFS, 1'b1, 32'h0);
    hit(26'h1E0);
    rdChk(wake_pkg::WAKE_SRC_OFS, 32'h0);
    xfer(wake_pkg::WAKE_CTRL_OFS, 1'b1, 32'hF);
    suspending <= 1;
    hit(26'h1000);
    `CHK(wakeSeen, 1'b0)
    rdChk(wake_pkg::WAKE_SRC_OFS, 32'h0);
    suspending <= 0;
    pulse(1'b0);
    hit(26'h1000);
    rdChk(wake_pkg::WAKE_SRC_OFS, 32'h0);
    pulse(1'b1);
    hit(26'h1000);
    hit(26'h80);
    xfer(wake_pkg::WAKE_CFG_OFS, 1'b1, 32'h3);
    pulse(1'b1);
    repeat (2) @(posedge clk_sys);
    rdChk(wake_pkg::WAKE_CTRL_OFS, 32'h0);
    `CHK(en, 4'h0)
    rdChk(wake_pkg::WAKE_SRC_OFS, 32'h8400);
    finishTest();
  end
  initial begin
    #200000;
    failCount++;
    finishTest();
  end
endmodule
